// File: common/mdr_pkg.sv
// Constants and types for the multiply-accumulate to data register datapath
`default_nettype none
package mdr_pkg;
  // Data path widths
  localparam int HALF_W = 16;
  localparam int DATA_W = 32;
  localparam int ACC_W = 40;
  // Special fraction operand and its saturated product
  localparam logic [15:0] FRAC_MIN_H = 16'h8000;
  localparam logic [31:0] PROD_SAT = 32'h7fff_ffff;
  // Saturation limits, held 42 bits wide with sign extension
  localparam logic signed [41:0] ACC_SMAX = 42'sh07f_ffff_ffff;
  localparam logic signed [41:0] ACC_SMIN = 42'sh380_0000_0000;
  localparam logic signed [41:0] ACC_UMAX = 42'sh0ff_ffff_ffff;
  localparam logic signed [41:0] ACC_UMIN = 42'sh000_0000_0000;
  localparam logic signed [41:0] DATA_SMAX = 42'sh000_7fff_ffff;
  localparam logic signed [41:0] DATA_SMIN = 42'sh3ff_8000_0000;
  localparam logic signed [41:0] DATA_UMAX = 42'sh000_ffff_ffff;
  localparam logic signed [41:0] DATA_UMIN = 42'sh000_0000_0000;
  // Reset values
  localparam logic [39:0] ACC_RESET = 40'h00_0000_0000;
  localparam logic [31:0] DATA_RESET = 32'h0000_0000;
  localparam logic [2:0] DEST_RESET = 3'h0;
  // Cycles from an accepted operation to its registered result
  localparam int RESULT_LAT = 1;
  // Accumulator update kinds
  typedef enum logic [1:0] {MDR_ACC_LOAD, MDR_ACC_ADD, MDR_ACC_SUB} mdr_accop_e;
  // Operation kinds
  typedef enum logic [2:0] {MDR_OP_MAC, MDR_OP_NEG_SHORT, MDR_OP_NEG_REG, MDR_OP_NEG_ACC,
                            MDR_OP_NEG_BOTH} mdr_opkind_e;
endpackage
`default_nettype wire

// File: design/mdr_datapath.sv
// Two-lane multiply-accumulate to data register datapath with negate forms
`default_nettype none
module mdr_datapath
  import mdr_pkg::*;
(
  // Clock, reset and enable
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  // Operation issue
  input wire logic op_valid_in,
  input wire mdr_opkind_e op_kind_in,
  input wire logic lane_in,
  input wire mdr_accop_e acc_op_in,
  input wire logic unsigned_frac_option_in,
  input wire logic int_signed_option_in,
  input wire logic doubled_round_frac_option_in,
  input wire logic mixed_option_in,
  input wire logic [HALF_W-1:0] src0_in,
  input wire logic [HALF_W-1:0] src1_in,
  input wire logic [1:0] dest_pair_in,
  // Negate operands
  input wire logic [DATA_W-1:0] neg_src_in,
  input wire logic neg_sat_in,
  input wire logic neg_acc_src_in,
  input wire logic neg_acc_dst_in,
  // Latched flag clears: bit 0 result, bit 1 acc zero, bit 2 acc one
  input wire logic [2:0] latched_clear_in,
  // Status and results
  output logic op_reject_out,
  output logic result_valid_out,
  output logic [DATA_W-1:0] result_out,
  output logic [2:0] result_dest_out,
  output logic [ACC_W-1:0] acc_zero_out,
  output logic [ACC_W-1:0] acc_one_out,
  output logic result_clip_flag_out,
  output logic result_clip_latched_out,
  output logic acc0_clip_flag_out,
  output logic acc0_clip_latched_out,
  output logic acc1_clip_flag_out,
  output logic acc1_clip_latched_out
);

  // Clamp v into [lo, hi]; top bit reports a clip
  function automatic logic [42:0] mdr_clamp(input logic signed [41:0] v,
                                            input logic signed [41:0] lo,
                                            input logic signed [41:0] hi);
    if (v > hi)
      mdr_clamp = {1'b1, hi};
    else if (v < lo)
      mdr_clamp = {1'b1, lo};
    else
      mdr_clamp = {1'b0, v};
  endfunction

  // Sign-extend an accumulator to working width
  function automatic logic signed [41:0] mdr_sext_acc(input logic [ACC_W-1:0] a);
    mdr_sext_acc = {{2{a[ACC_W-1]}}, a};
  endfunction

  logic [ACC_W-1:0] acc0_q, acc0_d, acc1_q, acc1_d;
  logic [DATA_W-1:0] result_q, result_d;
  logic [2:0] dest_q, dest_d;
  logic rvalid_q, rvalid_d;
  logic v_q, v_d, vs_q, vs_d, av0_q, av0_d, acc0_clip_latched_q, acc0_clip_latched_d, av1_q, av1_d, acc1_clip_latched_q, acc1_clip_latched_d;
  logic v_set, av0_set, av1_set;
  logic fu, frac_shift, opt_many, reject;
  logic signed [16:0] opa, opb;
  logic signed [33:0] prod;
  logic [31:0] prod32;
  logic signed [41:0] prod_ext, acc_base, sum, ext_src, neg_w;
  logic [ACC_W-1:0] acc_sel, acc_new;
  logic [42:0] acc_res, ext_res, dneg_res, an_res0, an_res1, an_resz;

  // Option check: mixed only on lane one, with at most one other option
  always_comb
  begin
    opt_many = (unsigned_frac_option_in & int_signed_option_in) |
               (unsigned_frac_option_in & doubled_round_frac_option_in) |
               (int_signed_option_in & doubled_round_frac_option_in);
    reject = op_valid_in & (op_kind_in == MDR_OP_MAC) &
             ((mixed_option_in & ~lane_in) | opt_many);
  end
  assign op_reject_out = reject;

  // Multiply, accumulate, extract and negate; next values of all state
  always_comb
  begin
    acc0_d = acc0_q;
    acc1_d = acc1_q;
    result_d = result_q;
    dest_d = dest_q;
    rvalid_d = 1'b0;
    v_d = v_q;
    av0_d = av0_q;
    av1_d = av1_q;
    v_set = 1'b0;
    av0_set = 1'b0;
    av1_set = 1'b0;
    fu = unsigned_frac_option_in;
    frac_shift = ~fu & ~int_signed_option_in & ~mixed_option_in;
    // Operand signedness: src0 signed unless plain unsigned fraction
    opa = {(~fu | mixed_option_in) & src0_in[HALF_W-1], src0_in};
    opb = {~fu & ~mixed_option_in & src1_in[HALF_W-1], src1_in};
    prod = opa * opb;
    prod32 = prod[31:0];
    if (frac_shift)
    begin
      if (src0_in == FRAC_MIN_H && src1_in == FRAC_MIN_H)
        prod32 = PROD_SAT;
      else
        prod32 = {prod[30:0], 1'b0};
    end
    // Zero-extend unsigned products, sign-extend the rest
    if (fu & ~mixed_option_in)
      prod_ext = {10'h000, prod32};
    else
      prod_ext = {{10{prod32[31]}}, prod32};
    acc_sel = lane_in ? acc1_q : acc0_q;
    acc_base = fu ? {2'h0, acc_sel} : mdr_sext_acc(acc_sel);
    case (acc_op_in)
      MDR_ACC_ADD: sum = acc_base + prod_ext;
      MDR_ACC_SUB: sum = acc_base - prod_ext;
      default: sum = prod_ext;
    endcase
    if (fu)
      acc_res = mdr_clamp(sum, ACC_UMIN, ACC_UMAX);
    else
      acc_res = mdr_clamp(sum, ACC_SMIN, ACC_SMAX);
    acc_new = acc_res[ACC_W-1:0];
    // Extraction works on a copy; no rounding step exists on this path
    ext_src = fu ? {2'h0, acc_new} : mdr_sext_acc(acc_new);
    if (doubled_round_frac_option_in)
      ext_src = {ext_src[40:0], 1'b0};
    if (fu)
      ext_res = mdr_clamp(ext_src, DATA_UMIN, DATA_UMAX);
    else
      ext_res = mdr_clamp(ext_src, DATA_SMIN, DATA_SMAX);
    // Negations
    neg_w = 42'sh000_0000_0000 - {{10{neg_src_in[31]}}, neg_src_in};
    dneg_res = mdr_clamp(neg_w, DATA_SMIN, DATA_SMAX);
    an_res0 = mdr_clamp(42'sh000_0000_0000 - mdr_sext_acc(neg_acc_src_in ? acc1_q : acc0_q),
                        ACC_SMIN, ACC_SMAX);
    an_res1 = mdr_clamp(42'sh000_0000_0000 - mdr_sext_acc(acc1_q), ACC_SMIN, ACC_SMAX);
    an_resz = mdr_clamp(42'sh000_0000_0000 - mdr_sext_acc(acc0_q), ACC_SMIN, ACC_SMAX);
    if (op_valid_in && !reject)
    begin
      case (op_kind_in)
        MDR_OP_MAC:
        begin
          if (lane_in)
          begin
            acc1_d = acc_new;
            av1_d = acc_res[42];
            av1_set = acc_res[42];
          end
          else
          begin
            acc0_d = acc_new;
            av0_d = acc_res[42];
            av0_set = acc_res[42];
          end
          result_d = ext_res[DATA_W-1:0];
          dest_d = {dest_pair_in, lane_in};
          rvalid_d = 1'b1;
          v_d = ext_res[42];
          v_set = ext_res[42];
        end
        MDR_OP_NEG_SHORT, MDR_OP_NEG_REG:
        begin
          // Short form always wraps; long form follows the select
          if (op_kind_in == MDR_OP_NEG_REG && neg_sat_in)
            result_d = dneg_res[DATA_W-1:0];
          else
            result_d = neg_w[DATA_W-1:0];
          dest_d = {dest_pair_in, lane_in};
          rvalid_d = 1'b1;
          v_d = dneg_res[42];
          v_set = dneg_res[42];
        end
        MDR_OP_NEG_ACC:
        begin
          if (neg_acc_dst_in)
          begin
            acc1_d = an_res0[ACC_W-1:0];
            av1_d = an_res0[42];
            av1_set = an_res0[42];
          end
          else
          begin
            acc0_d = an_res0[ACC_W-1:0];
            av0_d = an_res0[42];
            av0_set = an_res0[42];
          end
        end
        MDR_OP_NEG_BOTH:
        begin
          // Both accumulators negate in place; source and destination selects unused
          acc0_d = an_resz[ACC_W-1:0];
          acc1_d = an_res1[ACC_W-1:0];
          av0_d = an_resz[42];
          av0_set = an_resz[42];
          av1_d = an_res1[42];
          av1_set = an_res1[42];
        end
        default:
        begin
          rvalid_d = 1'b0;
        end
      endcase
    end
    // Latched copies: a set in the same cycle as a clear wins
    vs_d = v_set | (vs_q & ~latched_clear_in[0]);
    acc0_clip_latched_d = av0_set | (acc0_clip_latched_q & ~latched_clear_in[1]);
    acc1_clip_latched_d = av1_set | (acc1_clip_latched_q & ~latched_clear_in[2]);
  end

  // State registers; clock enable low freezes everything
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      acc0_q <= ACC_RESET;
      acc1_q <= ACC_RESET;
      result_q <= DATA_RESET;
      dest_q <= DEST_RESET;
      rvalid_q <= 1'b0;
      v_q <= 1'b0;
      vs_q <= 1'b0;
      av0_q <= 1'b0;
      acc0_clip_latched_q <= 1'b0;
      av1_q <= 1'b0;
      acc1_clip_latched_q <= 1'b0;
    end
    else if (clk_en_in)
    begin
      acc0_q <= acc0_d;
      acc1_q <= acc1_d;
      result_q <= result_d;
      dest_q <= dest_d;
      rvalid_q <= rvalid_d;
      v_q <= v_d;
      vs_q <= vs_d;
      av0_q <= av0_d;
      acc0_clip_latched_q <= acc0_clip_latched_d;
      av1_q <= av1_d;
      acc1_clip_latched_q <= acc1_clip_latched_d;
    end
  end

  // Outputs straight from registers
  assign result_valid_out = rvalid_q;
  assign result_out = result_q;
  assign result_dest_out = dest_q;
  assign acc_zero_out = acc0_q;
  assign acc_one_out = acc1_q;
  assign result_clip_flag_out = v_q;
  assign result_clip_latched_out = vs_q;
  assign acc0_clip_flag_out = av0_q;
  assign acc0_clip_latched_out = acc0_clip_latched_q;
  assign acc1_clip_flag_out = av1_q;
  assign acc1_clip_latched_out = acc1_clip_latched_q;

  // Checks on the datapath
  default clocking mdr_cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);

  sequence s_mac_go;
    clk_en_in && op_valid_in && op_kind_in == MDR_OP_MAC && !reject;
  endsequence

  sequence s_frac_min_sq;
    s_mac_go ##0 (!lane_in && acc_op_in == MDR_ACC_LOAD && !unsigned_frac_option_in &&
                  !int_signed_option_in && !doubled_round_frac_option_in &&
                  src0_in == 16'h8000 && src1_in == 16'h8000);
  endsequence

  sequence s_fu_min_sq;
    s_mac_go ##0 (lane_in && acc_op_in == MDR_ACC_LOAD && unsigned_frac_option_in &&
                  !mixed_option_in && src0_in == 16'h8000 && src1_in == 16'h8000);
  endsequence

  sequence s_doubled_round_frac_option_quarter;
    s_mac_go ##0 (!lane_in && acc_op_in == MDR_ACC_LOAD && doubled_round_frac_option_in &&
                  src0_in == 16'h4000 && src1_in == 16'h4000);
  endsequence

  a_lane_dest_parity: assert property (s_mac_go |=> result_valid_out &&
    result_dest_out[0] == $past(lane_in)) else $error("lane and destination parity differ");
  a_mixed_lane_zero: assert property (clk_en_in && op_valid_in && op_kind_in == MDR_OP_MAC &&
    mixed_option_in && !lane_in |=> !result_valid_out && $stable(acc_zero_out))
    else $error("mixed option accepted on lane zero");
  a_frac_min_prod: assert property (s_frac_min_sq |=> acc_zero_out == 40'h00_7fff_ffff &&
    result_out == 32'h7fff_ffff) else $error("most negative square not saturated");
  a_fu_min_prod: assert property (s_fu_min_sq |=> acc_one_out == 40'h00_4000_0000 &&
    result_out == 32'h4000_0000) else $error("unsigned square wrong");
  a_scaled_extract: assert property (s_doubled_round_frac_option_quarter |=> acc_zero_out == 40'h00_2000_0000 &&
    result_out == 32'h4000_0000) else $error("scaled extraction or accumulator wrong");
  a_clip_sticky: assert property (result_clip_flag_out && $changed(result_clip_flag_out)
    |-> result_clip_latched_out) else $error("result latched copy missed");
  a_clip_value: assert property (s_mac_go ##0 !unsigned_frac_option_in ##1
    result_clip_flag_out |-> result_out == 32'h7fff_ffff || result_out == 32'h8000_0000)
    else $error("clip flag without limit value");
  a_neg_sat: assert property (clk_en_in && op_valid_in && op_kind_in == MDR_OP_NEG_REG &&
    neg_sat_in && neg_src_in == 32'h8000_0000 |=> result_out == 32'h7fff_ffff &&
    result_clip_flag_out) else $error("saturating negate wrong");
  a_neg_wrap: assert property (clk_en_in && op_valid_in && op_kind_in == MDR_OP_NEG_SHORT &&
    neg_src_in == 32'h8000_0000 |=> result_out == 32'h8000_0000)
    else $error("wrapping negate wrong");
  a_flags_idle: assert property (!op_valid_in && latched_clear_in == 3'h0 |=>
    $stable({result_clip_flag_out, result_clip_latched_out, acc0_clip_flag_out,
             acc0_clip_latched_out, acc1_clip_flag_out, acc1_clip_latched_out}))
    else $error("flags moved without an operation");
  a_acc0_clip: assert property (s_mac_go ##0 !lane_in ##1 acc0_clip_flag_out |->
    acc0_clip_latched_out) else $error("acc zero latched copy missed");

endmodule // mdr_datapath
`default_nettype wire

// File: test/mdr_issue_model.sv
// Issue-side model of the core decoder presenting one operation at a time
`default_nettype none
module mdr_issue_model
  import mdr_pkg::*;
(
  // Clock and answer from the datapath
  input wire logic clk_in,
  input wire logic op_reject_in,
  // Operation fields
  output logic op_valid_out,
  output mdr_opkind_e op_kind_out,
  output logic lane_out,
  output mdr_accop_e acc_op_out,
  output logic [5:0] opt_out,
  output logic [15:0] src0_out,
  output logic [15:0] src1_out,
  output logic [31:0] neg_src_out,
  output logic [2:0] neg_ctl_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero
  initial
  begin
    op_valid_out = 1'h0;
    op_kind_out = MDR_OP_MAC;
    lane_out = 1'h0;
    acc_op_out = MDR_ACC_LOAD;
    opt_out = 6'h00;
    src0_out = 16'h0000;
    src1_out = 16'h0000;
    neg_src_out = 32'h0000_0000;
    neg_ctl_out = 3'h0;
  end

  // One operation: present at an edge, hold to the taking edge, then scramble operands
  task automatic issue(input mdr_opkind_e k, input logic ln, input mdr_accop_e a,
                       input logic [5:0] o, input logic [15:0] x, input logic [15:0] y,
                       input logic [31:0] n, input logic [2:0] ng, output logic rej);
    @(posedge clk_in);
    op_valid_out <= 1'h1;
    op_kind_out <= k;
    lane_out <= ln;
    acc_op_out <= a;
    opt_out <= o;
    src0_out <= x;
    src1_out <= y;
    neg_src_out <= n;
    neg_ctl_out <= ng;
    @(posedge clk_in);
    rej = op_reject_in;
    op_valid_out <= 1'h0;
    src0_out <= ~x;
    src1_out <= ~y;
    neg_src_out <= ~n;
    #1;
  endtask
endmodule // mdr_issue_model
`default_nettype wire

// File: test/testbench.sv
// Self-checking testbench for the multiply-accumulate to data register datapath
`default_nettype none
module testbench import mdr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam mdr_accop_e LD = MDR_ACC_LOAD, AD = MDR_ACC_ADD, SB = MDR_ACC_SUB;
  logic clk_in, reset_n_in, clk_en, op_valid, lane, reject, rvalid, rj;
  logic v, vs, av0, acc0_clip_latched, av1, acc1_clip_latched;
  logic [2:0] clr, nctl, dest;
  logic [5:0] opt;
  logic [15:0] s0, s1;
  logic [31:0] nsrc, res;
  logic [39:0] acc0, acc1;
  mdr_opkind_e kind;
  mdr_accop_e aop;
  int num_errors = 0;
  int cmp_count = 0;

  // Operation source and device under test
  mdr_issue_model u_iss (.clk_in(clk_in), .op_reject_in(reject), .op_valid_out(op_valid),
    .op_kind_out(kind), .lane_out(lane), .acc_op_out(aop), .opt_out(opt), .src0_out(s0),
    .src1_out(s1), .neg_src_out(nsrc), .neg_ctl_out(nctl));
  mdr_datapath dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en),
    .op_valid_in(op_valid), .op_kind_in(kind), .lane_in(lane), .acc_op_in(aop),
    .unsigned_frac_option_in(opt[0]), .int_signed_option_in(opt[1]),
    .doubled_round_frac_option_in(opt[2]), .mixed_option_in(opt[3]), .src0_in(s0),
    .src1_in(s1), .dest_pair_in(opt[5:4]), .neg_src_in(nsrc), .neg_sat_in(nctl[2]),
    .neg_acc_src_in(nctl[1]), .neg_acc_dst_in(nctl[0]), .latched_clear_in(clr),
    .op_reject_out(reject), .result_valid_out(rvalid), .result_out(res),
    .result_dest_out(dest), .acc_zero_out(acc0), .acc_one_out(acc1),
    .result_clip_flag_out(v), .result_clip_latched_out(vs), .acc0_clip_flag_out(av0),
    .acc0_clip_latched_out(acc0_clip_latched), .acc1_clip_flag_out(av1), .acc1_clip_latched_out(acc1_clip_latched));

  // 40 MHz clock
  initial
  begin
    clk_in = 1'h0;
    forever #12.5 clk_in = ~clk_in;
  end

  task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Issue one operation and compare status, result, flags and the accumulator of the selected lane
  task automatic run(input mdr_opkind_e k, input logic ln, input mdr_accop_e a,
                     input logic [5:0] o, input logic [15:0] x, input logic [15:0] y,
                     input logic [31:0] n, input logic [2:0] ng, input logic [31:0] er,
                     input logic [39:0] ea, input logic [5:0] ef);
    logic r;
    logic ej;
    logic ev;
    ej = (k == MDR_OP_MAC) && ((o[3] && !ln) || (2'(o[0]) + 2'(o[1]) + 2'(o[2]) > 2'h1));
    ev = !ej && (k inside {MDR_OP_MAC, MDR_OP_NEG_SHORT, MDR_OP_NEG_REG});
    u_iss.issue(k, ln, a, o, x, y, n, ng, r);
    chk("op_reject_out", 40'(ej), 40'(r));
    chk("result_valid_out", 40'(ev), 40'(rvalid));
    if (ev && k == MDR_OP_MAC)
      chk("result_dest_out", 40'({o[5:4], ln}), 40'(dest));
    chk("result_out", 40'(er), 40'(res));
    chk("accumulator", ea, ln ? acc1 : acc0);
    chk("flags", 40'(ef), 40'({v, vs, av0, acc0_clip_latched, av1, acc1_clip_latched}));
  endtask

  task automatic mac(input logic ln, input mdr_accop_e a, input logic [5:0] o,
                     input logic [15:0] x, input logic [15:0] y, input logic [31:0] er,
                     input logic [39:0] ea, input logic [5:0] ef);
    run(MDR_OP_MAC, ln, a, o, x, y, 32'h0, 3'h0, er, ea, ef);
  endtask

  task automatic neg(input mdr_opkind_e k, input logic [31:0] n, input logic [2:0] ng,
                     input logic ln, input logic [31:0] er, input logic [39:0] ea,
                     input logic [5:0] ef);
    run(k, ln, LD, 6'h0, 16'h0, 16'h0, n, ng, er, ea, ef);
  endtask

  task automatic conclude();
    if (num_errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Watchdog well beyond the expected run of about 1100 cycles
  initial
  begin
    repeat (5000) @(posedge clk_in);
    num_errors++;
    conclude();
  end

  // Main sequence; flags compare as {V, VS, AV0, ACC0_CLIP_LATCHED, AV1, ACC1_CLIP_LATCHED}
  initial
  begin
    reset_n_in = 1'h0;
    clr = 3'h0;
    clk_en = 1'h1;
    repeat (16) @(posedge clk_in);
    reset_n_in <= 1'h1;
    #1;
    chk("acc_zero_out", 40'h0, acc0);
    chk("flags", 40'h0, 40'({v, vs, av0, acc0_clip_latched, av1, acc1_clip_latched}));
    mac(1'h0, LD, 6'h10, 16'h8000, 16'h8000, 32'h7fffffff, 40'h007fffffff, 6'h00);
    mac(1'h0, AD, 6'h00, 16'h8000, 16'h8000, 32'h7fffffff, 40'h00fffffffe, 6'h30);
    mac(1'h0, SB, 6'h00, 16'h8000, 16'h8000, 32'h7fffffff, 40'h007fffffff, 6'h10);
    mac(1'h0, LD, 6'h00, 16'h8000, 16'h7fff, 32'h80010000, 40'hff80010000, 6'h10);
    mac(1'h0, SB, 6'h00, 16'h7fff, 16'h7fff, 32'h80000000, 40'hff0002fffe, 6'h30);
    mac(1'h0, LD, 6'h01, 16'h8000, 16'h8000, 32'h40000000, 40'h0040000000, 6'h10);
    mac(1'h0, AD, 6'h01, 16'hffff, 16'hffff, 32'hffffffff, 40'h013ffe0001, 6'h30);
    mac(1'h0, SB, 6'h01, 16'hffff, 16'hffff, 32'h40000000, 40'h0040000000, 6'h10);
    mac(1'h0, SB, 6'h01, 16'hffff, 16'hffff, 32'h00000000, 40'h0000000000, 6'h1c);
    // Clear the sticky copies while the live flags stay
    @(posedge clk_in);
    clr <= 3'h7;
    @(posedge clk_in);
    clr <= 3'h0;
    #1;
    chk("flags", 40'h08, 40'({v, vs, av0, acc0_clip_latched, av1, acc1_clip_latched}));
    mac(1'h0, LD, 6'h04, 16'h4000, 16'h4000, 32'h40000000, 40'h0020000000, 6'h00);
    // Hold the result clear while a clip sets the flag: the set wins
    clr <= 3'h1;
    mac(1'h0, AD, 6'h04, 16'h4000, 16'h4000, 32'h7fffffff, 40'h0040000000, 6'h30);
    clr <= 3'h0;
    mac(1'h0, LD, 6'h08, 16'h8000, 16'h8000, 32'h7fffffff, 40'h0040000000, 6'h30);
    mac(1'h1, LD, 6'h03, 16'h8000, 16'h8000, 32'h7fffffff, 40'h0000000000, 6'h30);
    mac(1'h1, LD, 6'h08, 16'h8000, 16'h8000, 32'hc0000000, 40'hffc0000000, 6'h10);
    mac(1'h1, LD, 6'h0a, 16'h7fff, 16'hffff, 32'h7ffe8001, 40'h007ffe8001, 6'h10);
    mac(1'h1, LD, 6'h22, 16'h8000, 16'h8000, 32'h40000000, 40'h0040000000, 6'h10);
    mac(1'h1, SB, 6'h02, 16'h8000, 16'h7fff, 32'h7fff8000, 40'h007fff8000, 6'h10);
    // Climb accumulator one to just under its positive limit
    repeat (509) u_iss.issue(MDR_OP_MAC, 1'h1, AD, 6'h02, 16'h8000, 16'h8000, 32'h0, 3'h0, rj);
    mac(1'h1, AD, 6'h02, 16'h8000, 16'h8000, 32'h7fffffff, 40'h7fffff8000, 6'h30);
    mac(1'h1, AD, 6'h02, 16'h8000, 16'h8000, 32'h7fffffff, 40'h7fffffffff, 6'h33);
    mac(1'h1, SB, 6'h02, 16'h8000, 16'h8000, 32'h7fffffff, 40'h7fbfffffff, 6'h31);
    neg(MDR_OP_NEG_REG, 32'h80000000, 3'h4, 1'h0, 32'h7fffffff, 40'h0040000000, 6'h31);
    neg(MDR_OP_NEG_REG, 32'h80000000, 3'h0, 1'h0, 32'h80000000, 40'h0040000000, 6'h31);
    neg(MDR_OP_NEG_REG, 32'h00000003, 3'h4, 1'h0, 32'hfffffffd, 40'h0040000000, 6'h11);
    neg(MDR_OP_NEG_SHORT, 32'h80000000, 3'h4, 1'h0, 32'h80000000, 40'h0040000000, 6'h31);
    neg(MDR_OP_NEG_ACC, 32'h0, 3'h1, 1'h1, 32'h80000000, 40'hffc0000000, 6'h31);
    neg(MDR_OP_NEG_ACC, 32'h0, 3'h3, 1'h1, 32'h80000000, 40'h0040000000, 6'h31);
    neg(MDR_OP_NEG_BOTH, 32'h0, 3'h0, 1'h0, 32'h80000000, 40'hffc0000000, 6'h31);
    chk("acc_one_out", 40'hffc0000000, acc1);
    // Mixed with unsigned fraction: signed product against an unsigned accumulator floor, then a plain unsigned fraction load
    mac(1'h1, LD, 6'h09, 16'h8000, 16'h8000, 32'h00000000, 40'h0000000000, 6'h13);
    mac(1'h1, LD, 6'h11, 16'h8000, 16'h8000, 32'h40000000, 40'h0040000000, 6'h11);
    // Clock enable low: the result pulse stands and an issued operation is not taken
    clk_en <= 1'h0;
    u_iss.issue(MDR_OP_MAC, 1'h0, LD, 6'h00, 16'h4000, 16'h4000, 32'h0, 3'h0, rj);
    chk("result_valid_out", 40'h1, 40'(rvalid));
    chk("acc_zero_out", 40'hffc0000000, acc0);
    chk("result_out", 40'h40000000, 40'(res));
    clk_en <= 1'h1;
    conclude();
  end
endmodule // testbench
`default_nettype wire
